// ==== design/wtb_defines.vh ====
// register map and field positions of the waveform timer block
`ifndef WTB_DEFINES_VH
`define WTB_DEFINES_VH
`define WTB_CH_STRIDE   8'h40
`define WTB_OFF_CCR     6'h00
`define WTB_OFF_CMR     6'h04
`define WTB_OFF_CV      6'h10
`define WTB_OFF_CMPA    6'h14
`define WTB_OFF_CMPB    6'h18
`define WTB_OFF_CMPC    6'h1C
`define WTB_OFF_SR      6'h20
`define WTB_OFF_IER     6'h24
`define WTB_OFF_IDR     6'h28
`define WTB_OFF_IMR     6'h2C
`define WTB_ADR_BCR     8'hC0
`define WTB_ADR_BMR     8'hC4
`define WTB_CCR_CLKEN   0
`define WTB_CCR_CLKDIS  1
`define WTB_CCR_SWTRIG  2
`define WTB_CMR_CLKSEL  2:0
`define WTB_CMR_INVERT  3
`define WTB_CMR_STOPC   6
`define WTB_CMR_DISC    7
`define WTB_CMR_EDGE    9:8
`define WTB_CMR_EVSEL   11:10
`define WTB_CMR_EVTRG   12
`define WTB_CMR_CTRG    14
`define WTB_CMR_WAVE    15
`define WTB_CMR_A_CMPA  17:16
`define WTB_CMR_A_CMPC  19:18
`define WTB_CMR_A_EVT   21:20
`define WTB_CMR_A_SW    23:22
`define WTB_CMR_B_CMPB  25:24
`define WTB_CMR_B_CMPC  27:26
`define WTB_CMR_B_EVT   29:28
`define WTB_CMR_B_SW    31:30
`define WTB_SR_CPA      2
`define WTB_SR_CPB      3
`define WTB_SR_CPC      4
`define WTB_SR_OVF      0
`define WTB_SR_ETRG     7
`define WTB_SR_CLKSTA   16
`define WTB_SR_MTIOA    17
`define WTB_SR_MTIOB    18
`define WTB_FLAG_MASK   8'h9D
`define WTB_ACT_NONE    2'h0
`define WTB_ACT_SET     2'h1
`define WTB_ACT_CLR     2'h2
`define WTB_ACT_TOG     2'h3
`define WTB_ROUTE_PIN   2'h0
`define WTB_ROUTE_NONE  2'h1
`define WTB_ROUTE_LO    2'h2
`define WTB_ROUTE_HI    2'h3
`define WTB_MAX_COUNT   16'hFFFF
`endif

// ==== design/wtb_top.v ====
// three-channel waveform timer with register port and clock routing
`timescale 1ns/10ps
`include "wtb_defines.vh"
module wtb_top #(
	parameter NCH = 3
) (
	input  wire         clk,
	input  wire         sys_rst,
	input  wire [7:0]   reg_addr,
	input  wire [31:0]  reg_wdata,
	input  wire         reg_wr,
	input  wire         reg_rd,
	output reg  [31:0]  reg_rdata,
	input  wire [2:0]   ext_clock_pin,
	input  wire [2:0]   io_line_a_in,
	output reg  [2:0]   io_line_a_out,
	output reg  [2:0]   io_line_a_oe,
	input  wire [2:0]   io_line_b_in,
	output reg  [2:0]   io_line_b_out,
	output reg  [2:0]   io_line_b_oe,
	output wire [2:0]   irq
);
////////////////////////////////////////////////////////////////////////////////
reg  [5:0]  bmr_q;
reg  [2:0]  ext_clock_line;
wire        bcr_hit = reg_wr && reg_addr == `WTB_ADR_BCR;
wire        sync_trig = bcr_hit && reg_wdata[0];
reg  [31:0] ch_rdata [0:NCH-1];
reg  [2:0]  ch_rd_hit_q;
reg         bmr_rd_q;

always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		bmr_q <= 6'h00;
		bmr_rd_q <= 1'b0;
	end else begin
		if (reg_wr && reg_addr == `WTB_ADR_BMR)
			bmr_q <= reg_wdata[5:0];
		bmr_rd_q <= reg_rd && reg_addr == `WTB_ADR_BMR;
	end
end

// external clock line muxing from pins or sibling line a outputs
always @* begin
	case (bmr_q[1:0])
	`WTB_ROUTE_PIN:  ext_clock_line[0] = ext_clock_pin[0];
	`WTB_ROUTE_LO:   ext_clock_line[0] = io_line_a_out[1];
	`WTB_ROUTE_HI:   ext_clock_line[0] = io_line_a_out[2];
	default:         ext_clock_line[0] = 1'b0;
	endcase
	case (bmr_q[3:2])
	`WTB_ROUTE_PIN:  ext_clock_line[1] = ext_clock_pin[1];
	`WTB_ROUTE_LO:   ext_clock_line[1] = io_line_a_out[0];
	`WTB_ROUTE_HI:   ext_clock_line[1] = io_line_a_out[2];
	default:         ext_clock_line[1] = 1'b0;
	endcase
	case (bmr_q[5:4])
	`WTB_ROUTE_PIN:  ext_clock_line[2] = ext_clock_pin[2];
	`WTB_ROUTE_LO:   ext_clock_line[2] = io_line_a_out[0];
	`WTB_ROUTE_HI:   ext_clock_line[2] = io_line_a_out[1];
	default:         ext_clock_line[2] = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
genvar g;
generate
for (g = 0; g < NCH; g = g + 1) begin : ch
	reg  [31:0] cmr_q;
	reg  [15:0] cv_q;
	reg  [15:0] cmpa_q;
	reg  [15:0] cmpb_q;
	reg  [15:0] cmpc_q;
	reg  [7:0]  sr_q;
	reg  [7:0]  imr_q;
	reg         clken_q;
	reg         run_q;
	reg  [6:0]  pre_q;
	reg         evsrc_prev_q;
	reg         tick_src_prev_q;
	reg  [31:0] rd_q;
	localparam [31:0] BASE = `WTB_CH_STRIDE * g;
	wire        hit  = reg_addr[7:6] == BASE[7:6];
	wire [5:0]  off  = reg_addr[5:0];
	wire        wr   = reg_wr && hit && reg_addr[7:6] != 2'h3;
	wire        rd   = reg_rd && hit && reg_addr[7:6] != 2'h3;
	wire        wave = cmr_q[`WTB_CMR_WAVE];
	wire        ccr_wr = wr && off == `WTB_OFF_CCR;
	wire        sw_trig = (ccr_wr && reg_wdata[`WTB_CCR_SWTRIG]) || sync_trig;
	wire        b_is_event = cmr_q[`WTB_CMR_EVSEL] == 2'h0;
	reg         ev_src;
	reg         ev_prev;
	reg         tick_src;
	reg         tick;
	reg         ext_evt;
	wire        c_match;
	wire        a_match;
	wire        b_match;
	wire        trig;
	wire        ovf;
	reg  [1:0]  a_act;
	reg  [1:0]  b_act;

	// event source choice: line b or one of the routed clock lines
	always @* begin
		case (cmr_q[`WTB_CMR_EVSEL])
		2'h0:    ev_src = io_line_b_in[g];
		2'h1:    ev_src = ext_clock_line[0];
		2'h2:    ev_src = ext_clock_line[1];
		default: ev_src = ext_clock_line[2];
		endcase
		ev_prev = evsrc_prev_q;
		case (cmr_q[`WTB_CMR_EDGE])
		2'h1:    ext_evt = ev_src && !ev_prev;
		2'h2:    ext_evt = !ev_src && ev_prev;
		2'h3:    ext_evt = ev_src != ev_prev;
		default: ext_evt = 1'b0;
		endcase
		case (cmr_q[`WTB_CMR_CLKSEL])
		3'h5:    tick_src = ext_clock_line[0];
		3'h6:    tick_src = ext_clock_line[1];
		3'h7:    tick_src = ext_clock_line[2];
		default: tick_src = 1'b0;
		endcase
		// internal prescaler taps; external lines counted on chosen edge
		case (cmr_q[`WTB_CMR_CLKSEL])
		3'h0:    tick = pre_q[0];
		3'h1:    tick = &pre_q[2:0];
		3'h2:    tick = &pre_q[4:0];
		3'h3:    tick = &pre_q[6:0];
		3'h4:    tick = &pre_q[6:0];
		default: tick = cmr_q[`WTB_CMR_INVERT] ? (!tick_src && tick_src_prev_q)
		               : (tick_src && !tick_src_prev_q);
		endcase
	end

	assign c_match = wave && run_q && tick && cv_q == cmpc_q;
	assign a_match = wave && run_q && tick && cv_q == cmpa_q;
	assign b_match = wave && run_q && tick && cv_q == cmpb_q;
	wire   etrig   = ext_evt && cmr_q[`WTB_CMR_EVTRG];
	assign trig    = sw_trig || etrig || (c_match && cmr_q[`WTB_CMR_CTRG]);
	assign ovf     = run_q && tick && cv_q == `WTB_MAX_COUNT;

	// the action of the highest priority event wins for each line, even when that action is none
	always @* begin
		a_act = `WTB_ACT_NONE;
		b_act = `WTB_ACT_NONE;
		if (sw_trig) begin
			a_act = cmr_q[`WTB_CMR_A_SW];
			b_act = cmr_q[`WTB_CMR_B_SW];
		end else if (ext_evt) begin
			a_act = cmr_q[`WTB_CMR_A_EVT];
			b_act = cmr_q[`WTB_CMR_B_EVT];
		end else if (c_match) begin
			a_act = cmr_q[`WTB_CMR_A_CMPC];
			b_act = cmr_q[`WTB_CMR_B_CMPC];
		end else begin
			a_act = a_match ? cmr_q[`WTB_CMR_A_CMPA] : `WTB_ACT_NONE;
			b_act = b_match ? cmr_q[`WTB_CMR_B_CMPB] : `WTB_ACT_NONE;
		end
	end

	assign irq[g] = |(sr_q & imr_q);

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmr_q <= 32'h00000000;
			cv_q <= 16'h0000;
			cmpa_q <= 16'h0000;
			cmpb_q <= 16'h0000;
			cmpc_q <= 16'h0000;
			sr_q <= 8'h00;
			imr_q <= 8'h00;
			clken_q <= 1'b0;
			run_q <= 1'b0;
			pre_q <= 7'h00;
			evsrc_prev_q <= 1'b0;
			tick_src_prev_q <= 1'b0;
			rd_q <= 32'h00000000;
			io_line_a_out[g] <= 1'b0;
			io_line_b_out[g] <= 1'b0;
			io_line_a_oe[g] <= 1'b0;
			io_line_b_oe[g] <= 1'b0;
		end else begin
			pre_q <= pre_q + 7'h01;
			evsrc_prev_q <= ev_src;
			tick_src_prev_q <= tick_src;
			if (wr && off == `WTB_OFF_CMR)
				cmr_q <= reg_wdata;
			if (wr && off == `WTB_OFF_CMPA && wave)
				cmpa_q <= reg_wdata[15:0];
			if (wr && off == `WTB_OFF_CMPB && wave)
				cmpb_q <= reg_wdata[15:0];
			if (wr && off == `WTB_OFF_CMPC)
				cmpc_q <= reg_wdata[15:0];
			if (wr && off == `WTB_OFF_IER)
				imr_q <= imr_q | (reg_wdata[7:0] & `WTB_FLAG_MASK);
			else if (wr && off == `WTB_OFF_IDR)
				imr_q <= imr_q & ~reg_wdata[7:0];
			// clock enable/disable; disable wins, trigger restarts if enabled
			if (ccr_wr && reg_wdata[`WTB_CCR_CLKDIS])
				clken_q <= 1'b0;
			else if (c_match && cmr_q[`WTB_CMR_DISC])
				clken_q <= 1'b0;
			else if (ccr_wr && reg_wdata[`WTB_CCR_CLKEN])
				clken_q <= 1'b1;
			if ((ccr_wr && reg_wdata[`WTB_CCR_CLKDIS]) || (c_match && cmr_q[`WTB_CMR_DISC]))
				run_q <= 1'b0;
			else if (trig)
				run_q <= clken_q || (ccr_wr && reg_wdata[`WTB_CCR_CLKEN]);
			else if (c_match && cmr_q[`WTB_CMR_STOPC])
				run_q <= 1'b0;
			else if (ccr_wr && reg_wdata[`WTB_CCR_CLKEN])
				run_q <= 1'b1;
			if (trig)
				cv_q <= 16'h0000;
			else if (run_q && tick)
				cv_q <= cv_q + 16'h0001;
			// flags: a new event beats the clear of a read in the same cycle
			sr_q <= ((rd && off == `WTB_OFF_SR) ? 8'h00 : sr_q)
			      | ({7'h00, ovf} << `WTB_SR_OVF)
			      | ({7'h00, a_match} << `WTB_SR_CPA)
			      | ({7'h00, b_match} << `WTB_SR_CPB)
			      | ({7'h00, c_match} << `WTB_SR_CPC)
			      | ({7'h00, etrig} << `WTB_SR_ETRG);
			io_line_a_oe[g] <= wave;
			io_line_b_oe[g] <= wave && !b_is_event;
			if (wave) begin
				case (a_act)
				`WTB_ACT_SET: io_line_a_out[g] <= 1'b1;
				`WTB_ACT_CLR: io_line_a_out[g] <= 1'b0;
				`WTB_ACT_TOG: io_line_a_out[g] <= !io_line_a_out[g];
				default:      io_line_a_out[g] <= io_line_a_out[g];
				endcase
				if (!b_is_event) begin
					case (b_act)
					`WTB_ACT_SET: io_line_b_out[g] <= 1'b1;
					`WTB_ACT_CLR: io_line_b_out[g] <= 1'b0;
					`WTB_ACT_TOG: io_line_b_out[g] <= !io_line_b_out[g];
					default:      io_line_b_out[g] <= io_line_b_out[g];
					endcase
				end
			end
			if (rd) begin
				case (off)
				`WTB_OFF_CMR: rd_q <= cmr_q;
				`WTB_OFF_CV:  rd_q <= {16'h0000, cv_q};
				`WTB_OFF_CMPA: rd_q <= {16'h0000, cmpa_q};
				`WTB_OFF_CMPB: rd_q <= {16'h0000, cmpb_q};
				`WTB_OFF_CMPC: rd_q <= {16'h0000, cmpc_q};
				`WTB_OFF_SR:  rd_q <= {13'h0000, io_line_b_in[g], io_line_a_out[g],
				                      clken_q, 8'h00, sr_q};
				`WTB_OFF_IMR: rd_q <= {24'h000000, imr_q};
				default:      rd_q <= 32'h00000000;
				endcase
			end
		end
	end
	always @* ch_rdata[g] = rd_q;
end
endgenerate

always @(posedge clk or posedge sys_rst) begin
	if (sys_rst)
		ch_rd_hit_q <= 3'h0;
	else
		ch_rd_hit_q <= {reg_rd && reg_addr[7:6] == 2'h2,
		                reg_rd && reg_addr[7:6] == 2'h1,
		                reg_rd && reg_addr[7:6] == 2'h0};
end

always @* begin
	reg_rdata = 32'h00000000;
	if (ch_rd_hit_q[0])
		reg_rdata = ch_rdata[0];
	else if (ch_rd_hit_q[1])
		reg_rdata = ch_rdata[1];
	else if (ch_rd_hit_q[2])
		reg_rdata = ch_rdata[2];
	else if (bmr_rd_q)
		reg_rdata = {26'h0000000, bmr_q};
end

endmodule

// ==== verif/wtb_top_props.sv ====
// port-level assertions of the waveform timer block
`timescale 1ns/10ps
module wtb_top_props #(
	parameter NCH = 3
) (
	input wire        clk,
	input wire        sys_rst,
	input wire [7:0]  reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	input wire [2:0]  io_line_a_out,
	input wire [2:0]  io_line_a_oe,
	input wire [2:0]  io_line_b_oe,
	input wire [2:0]  irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	reg [1:0] mode_wr_q;
	// enables may trail the mode write by one or two edges
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			mode_wr_q <= 2'h0;
		else
			mode_wr_q <= {mode_wr_q[0], reg_wr && reg_addr == 8'h04};
	end
	sequence s_no_read;
		!reg_rd ##1 1'b1;
	endsequence
	property p_rdata_quiet;
		s_no_read |-> reg_rdata == 32'h0;
	endproperty
	property p_irq_fall;
		(|($past(irq) & ~irq)) |-> $past(reg_rd || reg_wr);
	endproperty
	property p_a_oe_rise;
		$rose(io_line_a_oe[0]) |-> mode_wr_q != 2'h0;
	endproperty
	property p_a_oe_fall;
		$fell(io_line_a_oe[0]) |-> mode_wr_q != 2'h0;
	endproperty
	property p_b_oe_rise;
		$rose(io_line_b_oe[0]) |-> mode_wr_q != 2'h0;
	endproperty
	property p_b_oe_fall;
		$fell(io_line_b_oe[0]) |-> mode_wr_q != 2'h0;
	endproperty
	property p_b_needs_a;
		(io_line_b_oe & ~io_line_a_oe) == 3'h0;
	endproperty
	property p_a_idle;
		$changed(io_line_a_out[0]) |-> io_line_a_oe[0] || $past(io_line_a_oe[0]);
	endproperty
	a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside read slot");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
	a_a_oe_rise: assert property (p_a_oe_rise) else $error("line a enable rose alone");
	a_a_oe_fall: assert property (p_a_oe_fall) else $error("line a enable fell alone");
	a_b_oe_rise: assert property (p_b_oe_rise) else $error("line b enable rose alone");
	a_b_oe_fall: assert property (p_b_oe_fall) else $error("line b enable fell alone");
	a_b_needs_a: assert property (p_b_needs_a) else $error("line b driven outside wave");
	a_a_idle: assert property (p_a_idle) else $error("line a moved while idle");
endmodule
bind wtb_top wtb_top_props #(.NCH(NCH)) wtb_top_props_inst (.clk(clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.io_line_a_out(io_line_a_out), .io_line_a_oe(io_line_a_oe), .io_line_b_oe(io_line_b_oe),
	.irq(irq));

// ==== verif/wtb_pins_model.sv ====
// external pin model: clock pins and the far end of line b
`timescale 1ns/10ps
module wtb_pins_model (
	input  wire       clk,
	input  wire       sys_rst,
	input  wire [2:0] line_b_out,
	input  wire [2:0] line_b_oe,
	output reg  [2:0] ext_clock_pin,
	output wire [2:0] line_b_in
);
	reg [1:0] div_q;
	reg [2:0] idle_q;
	// pins toggle every four cycles, slow enough for synchronous sampling
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= 2'h0;
			ext_clock_pin <= 3'h0;
			idle_q <= 3'h5;
		end else begin
			div_q <= div_q + 2'h1;
			idle_q <= ~idle_q;
			if (div_q == 2'h3)
				ext_clock_pin <= ~ext_clock_pin;
		end
	end
	// undriven line b shows a changing pattern, never a stale level
	assign line_b_in = (line_b_oe & line_b_out) | (~line_b_oe & idle_q);
endmodule

// ==== verif/waveform_timer_block_bench.sv ====
// self-checking bench of the waveform timer block
`timescale 1ns/10ps
module waveform_timer_block_bench;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        rd_seen = 1'b0;
	logic [31:0] seed = 32'hCB9D6AE7;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [7:0]  addr_list[10] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h2C, 8'h44,
		8'h84, 8'hC4};
	wire  [31:0] reg_rdata;
	wire  [2:0]  pin, a_out, a_oe, b_in, b_out, b_oe, irq;
	int          err_count = 0;
	int          samples_checked = 0;
	always #4 clk = ~clk;
	wtb_top wtb_top_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clock_pin(pin),
		.io_line_a_in(a_out), .io_line_a_out(a_out), .io_line_a_oe(a_oe), .io_line_b_in(b_in),
		.io_line_b_out(b_out), .io_line_b_oe(b_oe), .irq(irq));
	wtb_pins_model wtb_pins_model_inst (.clk(clk), .sys_rst(sys_rst), .line_b_out(b_out),
		.line_b_oe(b_oe), .ext_clock_pin(pin), .line_b_in(b_in));
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp(input [31:0] got, input [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input [7:0] a, input [31:0] e, input [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	// pins have no completion flag, so give them a generous settle
	task automatic settle;
		repeat (40) @(negedge clk);
	endtask
	task automatic end_sim;
		$display("checked %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) rd_seen <= reg_rd;
	always @(negedge clk) begin
		if (rd_seen && exp_q.size() > 0)
			cmp(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		end_sim;
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (addr_list[i]) rd(addr_list[i], 32'h0, 32'hFFFFFFFF);
		$display("test reset done");
		seed = lfsr(seed);
		wr(8'h14, seed);
		rd(8'h14, 32'h0, 32'hFFFFFFFF);
		rd(8'h08, 32'h0, 32'hFFFFFFFF);
		wr(8'h44, 32'h8000);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			wr(8'h54 + 8'(i * 4), seed);
			rd(8'h54 + 8'(i * 4), seed, 32'hFFFF);
		end
		settle;
		cmp({29'h0, a_oe}, 32'h2);
		cmp({29'h0, b_oe}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(8'hC4, {26'h0, 2'(i), 2'(i), 2'(i)});
			rd(8'hC4, {26'h0, 2'(i), 2'(i), 2'(i)}, 32'hFFFFFFFF);
		end
		wr(8'hC4, 32'h0);
		wr(8'h24, 32'h9D);
		rd(8'h2C, 32'h9D, 32'h9D);
		wr(8'h28, 32'h8D);
		rd(8'h2C, 32'h10, 32'h9D);
		$display("test access done");
		wr(8'h04, 32'h01098440);
		wr(8'h14, 32'h2);
		wr(8'h18, 32'h3);
		wr(8'h1C, 32'h5);
		wr(8'h00, 32'h5);
		settle;
		cmp({31'h0, a_out[0]}, 32'h0);
		cmp({31'h0, b_out[0]}, 32'h1);
		cmp({31'h0, b_oe[0]}, 32'h1);
		cmp({31'h0, irq[0]}, 32'h1);
		rd(8'h20, 32'h1C, 32'h9D);
		rd(8'h20, 32'h0, 32'h9D);
		settle;
		cmp({31'h0, irq[0]}, 32'h0);
		wr(8'h04, 32'h01098040);
		settle;
		cmp({31'h0, b_oe[0]}, 32'h0);
		$display("test compare done");
		for (int c = 0; c < 3; c++) wr(8'h04 + 8'(c * 64), 32'h00408000);
		wr(8'hC0, 32'h0);
		settle;
		cmp({29'h0, a_out}, 32'h0);
		wr(8'hC0, 32'h1);
		settle;
		cmp({29'h0, a_out}, 32'h7);
		for (int c = 0; c < 3; c++) wr(8'h04 + 8'(c * 64), 32'h00C08000);
		wr(8'hC0, 32'h1);
		settle;
		cmp({29'h0, a_out}, 32'h0);
		wr(8'h40, 32'h4);
		settle;
		cmp({29'h0, a_out}, 32'h2);
		$display("test trigger done");
		rd(8'hA0, 32'h0, 32'h0);
		wr(8'h84, 32'h00109400);
		settle;
		rd(8'hA0, 32'h0, 32'h80);
		wr(8'h84, 32'h00109500);
		settle;
		rd(8'hA0, 32'h80, 32'h80);
		cmp({31'h0, a_out[2]}, 32'h1);
		$display("test event done");
		repeat (3) @(posedge clk);
		end_sim;
	end
endmodule
